// >>> verilog/rps_pkg.sv
`default_nettype none
package rps_pkg;
  // ==========================================================
  // sizes
  localparam int unsigned RPS_NUM_IO_PINS = 32;
  localparam int unsigned RPS_NUM_IN_ONLY_PINS = 14;
  localparam int unsigned RPS_NUM_PINS = 46;
  localparam int unsigned RPS_SEL_W = 6;
  localparam int unsigned RPS_NUM_MAP_REGS = 16;
  localparam int unsigned RPS_NUM_IN_SELS = 7;
  localparam int unsigned RPS_ADDR_W = 8;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] RPS_OFS_PIN_OUTPUT_MAP0 = 8'h00;
  localparam logic [7:0] RPS_OFS_SPI2_CLOCK_DATA_IN = 8'h40;
  localparam logic [7:0] RPS_OFS_SPI2_SELECT_IN = 8'h44;
  localparam logic [7:0] RPS_OFS_SERIAL4_IN = 8'h48;
  localparam logic [7:0] RPS_OFS_SPI3_CLOCK_DATA_IN = 8'h4C;
  localparam logic [7:0] RPS_OFS_ALTERNATE_MAPPING = 8'h50;
  localparam logic [7:0] RPS_OFS_ANALOG_CFG_LOW = 8'h54;
  localparam logic [7:0] RPS_OFS_ANALOG_CFG_HIGH = 8'h58;
  localparam logic [7:0] RPS_OFS_PIN_LEVEL_LOW = 8'h5C;
  localparam logic [7:0] RPS_OFS_PIN_LEVEL_HIGH = 8'h60;
  // ==========================================================
  // field positions
  localparam int unsigned RPS_LO_FIELD_POS = 0;
  localparam int unsigned RPS_HI_FIELD_POS = 8;
  localparam int unsigned RPS_ALT_CLOCK_MAP_POS = 0;
  localparam int unsigned RPS_HALF_BAND_GAP_POS = 0;
  localparam int unsigned RPS_BAND_GAP_POS = 1;
  // ==========================================================
  // reset values
  localparam logic [5:0] RPS_OUT_MAP_RST = 6'h00;
  localparam logic [5:0] RPS_IN_SEL_RST = 6'h3F;
  localparam logic [15:0] RPS_ANALOG_LOW_RST = 16'h0000;
  localparam logic [1:0] RPS_ANALOG_HIGH_RST = 2'h0;
  localparam logic RPS_ALT_MAP_RST = 1'b0;
  localparam logic RPS_UNMAPPED_IN_LEVEL = 1'b0;
  // ==========================================================
  // output function codes
  localparam logic [5:0] RPS_FN_NULL = 6'h00;
  localparam logic [63:0] RPS_FN_VALID_MASK = 64'h0000_001F_F3FC_1FFE;
  // input select slots
  localparam int unsigned RPS_IN_SPI2_CLK = 0;
  localparam int unsigned RPS_IN_SPI2_DATA = 1;
  localparam int unsigned RPS_IN_SPI2_SEL = 2;
  localparam int unsigned RPS_IN_SER4_CTS = 3;
  localparam int unsigned RPS_IN_SER4_RX = 4;
  localparam int unsigned RPS_IN_SPI3_CLK = 5;
  localparam int unsigned RPS_IN_SPI3_DATA = 6;
endpackage
`default_nettype wire

// >>> verilog/rps_remappable_pin_select.sv
// Summary of operation
// - a code written to a pin's output-map field drives that function out
// - reset puts the null code zero on every output map, pin undriven
// - codes 1, 2 pick comparators one, two; code 36 picks comparator three
// - codes 3-6 and 28-31 pick serial transmit and request-to-send outputs
// - codes 7-9, 10-12, 32-34 pick SPI one, two, three data, clock, select
// - codes 18-25 pick compare channels one to eight, code 35 channel nine
// - request-to-send carries the infrared bit clock in infrared mode
// - alternate clock-map bit sends SPI one clock to its fixed pin
// - each 6-bit input select routes that pin number; resets to all ones
// - SPI two clock select in bits 13-8, data in 5-0, rest read zero
// - SPI two slave-select select in bits 5-0, bits 15-6 read zero
// - serial four clear-to-send select bits 13-8, receive bits 5-0
// - SPI three clock select bits 13-8, data select bits 5-0
// - low analog bits: set is digital with port read, clear is analog
// - high analog bit 1 clear enables band-gap scan; bits 15-2 read zero
// - high analog bit 0 clear enables half band-gap scan channel
`timescale 1ns/100ps
`default_nettype none
module rps_remappable_pin_select (
  input wire logic ref_clk, // system clock, 250 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [rps_pkg::RPS_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  output logic [31:0] prdata, // apb read data
  input wire logic [2:0] comparator_out, // comparators one to three
  input wire logic [3:0] serial_transmit, // serial ports one to four
  input wire logic [3:0] serial_request_to_send, // serial ports one to four
  input wire logic [3:0] serial_infrared_mode, // port in infrared mode
  input wire logic [3:0] serial_infrared_bclk, // infrared bit clock
  input wire logic [2:0] spi_data_out, // spi ports one to three
  input wire logic [2:0] spi_clock_out, // spi ports one to three
  input wire logic [2:0] spi_select_out, // spi ports one to three
  input wire logic [8:0] compare_channel_out, // compare channels one to nine
  input wire logic [rps_pkg::RPS_NUM_PINS-1:0] remappable_pin_in, // pad levels
  output logic [rps_pkg::RPS_NUM_IO_PINS-1:0] remappable_io_pin_out, // data
  output logic [rps_pkg::RPS_NUM_IO_PINS-1:0] remappable_io_pin_oe, // enable
  output logic fixed_alt_spi_clock_pin_out, // fixed alternate clock pin
  output logic fixed_alt_spi_clock_pin_oe, // fixed alternate pin enable
  output logic spi_two_clock_in, // routed spi two clock input
  output logic spi_two_data_in, // routed spi two data input
  output logic spi_two_select_in, // routed spi two slave select
  output logic serial_four_cts_in, // routed serial four clear-to-send
  output logic serial_four_rx_in, // routed serial four receive
  output logic spi_three_clock_in, // routed spi three clock input
  output logic spi_three_data_in, // routed spi three data input
  output logic [15:0] pin_digital_mode, // pin digital, port read enabled
  output logic [15:0] converter_sample_enable, // pin analog, sampled
  output logic band_gap_scan_enable, // band-gap channel in scan
  output logic half_band_gap_scan_enable // half band-gap channel in scan
);
  import rps_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [5:0] rps_field_wr(input logic [5:0] old_val,
                                              input logic [7:0] lane,
                                              input logic strobe);
    rps_field_wr = strobe ? lane[5:0] : old_val;
  endfunction

  function automatic logic rps_pick_pin(input logic [5:0] sel,
                                        input logic [RPS_NUM_PINS-1:0] pins);
    logic level;
    level = RPS_UNMAPPED_IN_LEVEL;
    // selects past the last pin see an idle level, not a stale pin
    if (32'(sel) < RPS_NUM_PINS) begin
      level = pins[sel];
    end
    rps_pick_pin = level;
  endfunction

  function automatic logic [31:0] rps_pair(input logic [5:0] hi,
                                           input logic [5:0] lo);
    rps_pair = {18'h0, hi, 2'h0, lo};
  endfunction

  // ==========================================================
  // registers
  logic [5:0] out_map_q [RPS_NUM_IO_PINS];
  logic [5:0] in_sel_q [RPS_NUM_IN_SELS];
  logic alt_clock_map_bit_q;
  logic [15:0] analog_low_q;
  logic [1:0] analog_high_q;
  logic [RPS_NUM_PINS-1:0] pin_meta_q;
  logic [RPS_NUM_PINS-1:0] pin_sync_q;
  logic [31:0] prdata_q;
  logic addr_ok;
  logic wr_en;
  logic rd_setup;
  logic [31:0] rd_mux;
  logic [63:0] fn_src;
  logic [3:0] rts_eff;
  logic [3:0] map_idx;
  logic map_hit;

  assign map_hit = (paddr[7:6] == 2'b00);
  assign map_idx = paddr[5:2];

  // ==========================================================
  // apb slave: zero wait states, read data captured in setup
  always_comb begin
    addr_ok = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      if (map_hit) begin
        addr_ok = 1'b1;
      end else begin
        case (paddr)
          RPS_OFS_SPI2_CLOCK_DATA_IN,
          RPS_OFS_SPI2_SELECT_IN,
          RPS_OFS_SERIAL4_IN,
          RPS_OFS_SPI3_CLOCK_DATA_IN,
          RPS_OFS_ALTERNATE_MAPPING,
          RPS_OFS_ANALOG_CFG_LOW,
          RPS_OFS_ANALOG_CFG_HIGH,
          RPS_OFS_PIN_LEVEL_LOW,
          RPS_OFS_PIN_LEVEL_HIGH: addr_ok = 1'b1;
          default: addr_ok = 1'b0;
        endcase
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign prdata = prdata_q;

  always_comb begin
    rd_mux = 32'h0;
    if (map_hit) begin
      rd_mux = rps_pair(out_map_q[{map_idx, 1'b1}],
                        out_map_q[{map_idx, 1'b0}]);
    end else begin
      case (paddr)
        RPS_OFS_SPI2_CLOCK_DATA_IN: begin
          rd_mux = rps_pair(in_sel_q[RPS_IN_SPI2_CLK],
                            in_sel_q[RPS_IN_SPI2_DATA]);
        end
        RPS_OFS_SPI2_SELECT_IN: begin
          rd_mux = rps_pair(6'h00, in_sel_q[RPS_IN_SPI2_SEL]);
        end
        RPS_OFS_SERIAL4_IN: begin
          rd_mux = rps_pair(in_sel_q[RPS_IN_SER4_CTS],
                            in_sel_q[RPS_IN_SER4_RX]);
        end
        RPS_OFS_SPI3_CLOCK_DATA_IN: begin
          rd_mux = rps_pair(in_sel_q[RPS_IN_SPI3_CLK],
                            in_sel_q[RPS_IN_SPI3_DATA]);
        end
        RPS_OFS_ALTERNATE_MAPPING: rd_mux = {31'h0, alt_clock_map_bit_q};
        RPS_OFS_ANALOG_CFG_LOW: rd_mux = {16'h0, analog_low_q};
        RPS_OFS_ANALOG_CFG_HIGH: rd_mux = {30'h0, analog_high_q};
        RPS_OFS_PIN_LEVEL_LOW: rd_mux = pin_sync_q[31:0];
        RPS_OFS_PIN_LEVEL_HIGH: begin
          rd_mux = {18'h0, pin_sync_q[RPS_NUM_PINS-1:32]};
        end
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // output map fields, two pins per word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < RPS_NUM_IO_PINS; i++) begin
        out_map_q[i] <= RPS_OUT_MAP_RST;
      end
    end else if (wr_en && map_hit) begin
      out_map_q[{map_idx, 1'b0}] <= rps_field_wr(out_map_q[{map_idx, 1'b0}],
                                                 pwdata[7:0], pstrb[0]);
      out_map_q[{map_idx, 1'b1}] <= rps_field_wr(out_map_q[{map_idx, 1'b1}],
                                                 pwdata[15:8], pstrb[1]);
    end
  end

  // ==========================================================
  // input select fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < RPS_NUM_IN_SELS; i++) begin
        in_sel_q[i] <= RPS_IN_SEL_RST;
      end
    end else if (wr_en) begin
      case (paddr)
        RPS_OFS_SPI2_CLOCK_DATA_IN: begin
          in_sel_q[RPS_IN_SPI2_CLK] <= rps_field_wr(
            in_sel_q[RPS_IN_SPI2_CLK], pwdata[15:8], pstrb[1]);
          in_sel_q[RPS_IN_SPI2_DATA] <= rps_field_wr(
            in_sel_q[RPS_IN_SPI2_DATA], pwdata[7:0], pstrb[0]);
        end
        RPS_OFS_SPI2_SELECT_IN: begin
          in_sel_q[RPS_IN_SPI2_SEL] <= rps_field_wr(
            in_sel_q[RPS_IN_SPI2_SEL], pwdata[7:0], pstrb[0]);
        end
        RPS_OFS_SERIAL4_IN: begin
          in_sel_q[RPS_IN_SER4_CTS] <= rps_field_wr(
            in_sel_q[RPS_IN_SER4_CTS], pwdata[15:8], pstrb[1]);
          in_sel_q[RPS_IN_SER4_RX] <= rps_field_wr(
            in_sel_q[RPS_IN_SER4_RX], pwdata[7:0], pstrb[0]);
        end
        RPS_OFS_SPI3_CLOCK_DATA_IN: begin
          in_sel_q[RPS_IN_SPI3_CLK] <= rps_field_wr(
            in_sel_q[RPS_IN_SPI3_CLK], pwdata[15:8], pstrb[1]);
          in_sel_q[RPS_IN_SPI3_DATA] <= rps_field_wr(
            in_sel_q[RPS_IN_SPI3_DATA], pwdata[7:0], pstrb[0]);
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // alternate mapping and analog configuration
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_clock_map_bit_q <= RPS_ALT_MAP_RST;
      analog_low_q <= RPS_ANALOG_LOW_RST;
      analog_high_q <= RPS_ANALOG_HIGH_RST;
    end else if (wr_en) begin
      case (paddr)
        RPS_OFS_ALTERNATE_MAPPING: begin
          if (pstrb[0]) begin
            alt_clock_map_bit_q <= pwdata[RPS_ALT_CLOCK_MAP_POS];
          end
        end
        RPS_OFS_ANALOG_CFG_LOW: begin
          if (pstrb[0]) begin
            analog_low_q[7:0] <= pwdata[7:0];
          end
          if (pstrb[1]) begin
            analog_low_q[15:8] <= pwdata[15:8];
          end
        end
        RPS_OFS_ANALOG_CFG_HIGH: begin
          if (pstrb[0]) begin
            analog_high_q <= pwdata[1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // pad synchroniser; only the second stage is read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= remappable_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==========================================================
  // output function sources, indexed by function code
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rts_eff[i] = serial_infrared_mode[i] ? serial_infrared_bclk[i]
                                           : serial_request_to_send[i];
    end
  end

  always_comb begin
    fn_src = 64'h0;
    fn_src[1] = comparator_out[0];
    fn_src[2] = comparator_out[1];
    fn_src[36] = comparator_out[2];
    fn_src[3] = serial_transmit[0];
    fn_src[4] = rts_eff[0];
    fn_src[5] = serial_transmit[1];
    fn_src[6] = rts_eff[1];
    fn_src[28] = serial_transmit[2];
    fn_src[29] = rts_eff[2];
    fn_src[30] = serial_transmit[3];
    fn_src[31] = rts_eff[3];
    for (int s = 0; s < 2; s++) begin
      fn_src[7 + 3 * s] = spi_data_out[s];
      fn_src[8 + 3 * s] = spi_clock_out[s];
      fn_src[9 + 3 * s] = spi_select_out[s];
    end
    fn_src[32] = spi_data_out[2];
    fn_src[33] = spi_clock_out[2];
    fn_src[34] = spi_select_out[2];
    for (int c = 0; c < 8; c++) begin
      fn_src[18 + c] = compare_channel_out[c];
    end
    fn_src[35] = compare_channel_out[8];
  end

  // registered so the pads see no glitches from the code mux
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      remappable_io_pin_out <= '0;
      remappable_io_pin_oe <= '0;
    end else begin
      for (int p = 0; p < RPS_NUM_IO_PINS; p++) begin
        remappable_io_pin_out[p] <= fn_src[out_map_q[p]];
        // null and unlisted codes leave the pad undriven
        remappable_io_pin_oe[p] <= RPS_FN_VALID_MASK[out_map_q[p]];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fixed_alt_spi_clock_pin_out <= 1'b0;
      fixed_alt_spi_clock_pin_oe <= 1'b0;
    end else begin
      fixed_alt_spi_clock_pin_out <= alt_clock_map_bit_q &
                                     spi_clock_out[0];
      fixed_alt_spi_clock_pin_oe <= alt_clock_map_bit_q;
    end
  end

  // ==========================================================
  // input routing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_two_clock_in <= RPS_UNMAPPED_IN_LEVEL;
      spi_two_data_in <= RPS_UNMAPPED_IN_LEVEL;
      spi_two_select_in <= RPS_UNMAPPED_IN_LEVEL;
      serial_four_cts_in <= RPS_UNMAPPED_IN_LEVEL;
      serial_four_rx_in <= RPS_UNMAPPED_IN_LEVEL;
      spi_three_clock_in <= RPS_UNMAPPED_IN_LEVEL;
      spi_three_data_in <= RPS_UNMAPPED_IN_LEVEL;
    end else begin
      spi_two_clock_in <= rps_pick_pin(in_sel_q[RPS_IN_SPI2_CLK],
                                       pin_sync_q);
      spi_two_data_in <= rps_pick_pin(in_sel_q[RPS_IN_SPI2_DATA],
                                      pin_sync_q);
      spi_two_select_in <= rps_pick_pin(in_sel_q[RPS_IN_SPI2_SEL],
                                        pin_sync_q);
      serial_four_cts_in <= rps_pick_pin(in_sel_q[RPS_IN_SER4_CTS],
                                         pin_sync_q);
      serial_four_rx_in <= rps_pick_pin(in_sel_q[RPS_IN_SER4_RX],
                                        pin_sync_q);
      spi_three_clock_in <= rps_pick_pin(in_sel_q[RPS_IN_SPI3_CLK],
                                         pin_sync_q);
      spi_three_data_in <= rps_pick_pin(in_sel_q[RPS_IN_SPI3_DATA],
                                        pin_sync_q);
    end
  end

  // ==========================================================
  // analog configuration outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_digital_mode <= '0;
      converter_sample_enable <= '0;
      band_gap_scan_enable <= 1'b0;
      half_band_gap_scan_enable <= 1'b0;
    end else begin
      pin_digital_mode <= analog_low_q;
      converter_sample_enable <= ~analog_low_q;
      band_gap_scan_enable <= ~analog_high_q[RPS_BAND_GAP_POS];
      half_band_gap_scan_enable <=
        ~analog_high_q[RPS_HALF_BAND_GAP_POS];
    end
  end

endmodule
`default_nettype wire

// >>> bench/rps_properties.sv
`timescale 1ns/100ps
`default_nettype none
module rps_checker (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [rps_pkg::RPS_ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // data
  input wire logic [3:0] pstrb, // strobes
  input wire logic [2:0] comparator_out, // comparators
  input wire logic [3:0] serial_transmit, // transmit
  input wire logic [3:0] serial_request_to_send, // rts
  input wire logic [3:0] serial_infrared_mode, // infrared
  input wire logic [3:0] serial_infrared_bclk, // bit clock
  input wire logic [2:0] spi_clock_out, // spi clocks
  input wire logic [8:0] compare_channel_out, // compare
  input wire logic [rps_pkg::RPS_NUM_IO_PINS-1:0] remappable_io_pin_out, // out
  input wire logic [rps_pkg::RPS_NUM_IO_PINS-1:0] remappable_io_pin_oe, // oe
  input wire logic [15:0] pin_digital_mode, // digital
  input wire logic [15:0] converter_sample_enable, // analog
  input wire logic band_gap_scan_enable, // scan
  input wire logic half_band_gap_scan_enable, // scan
  input wire logic spi_two_clock_in // routed
);
  import rps_pkg::*;
  // ==========================================================
  logic map0_wr;
  logic [5:0] code0_q;
  assign map0_wr = psel && penable && pwrite && pstrb[0]
                   && paddr == RPS_OFS_PIN_OUTPUT_MAP0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code0_q <= RPS_OUT_MAP_RST;
    end else if (map0_wr) begin
      code0_q <= pwdata[5:0];
    end
  end
  // ==========================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence release_s;
    $rose(rst_n);
  endsequence
  sequence map0_write_s;
    map0_wr;
  endsequence
  reset_state_a: assert property (release_s |=>
    remappable_io_pin_oe == '0 && converter_sample_enable == 16'hFFFF
    && band_gap_scan_enable && half_band_gap_scan_enable)
    else $error("outputs wrong after reset");
  route_reset_a: assert property (release_s |=> !spi_two_clock_in)
    else $error("routed input not idle after reset");
  conv_inverse_a: assert property ($past(rst_n) |->
    converter_sample_enable == ~pin_digital_mode)
    else $error("sample enable not inverse of digital mode");
  oe_write_a: assert property (map0_write_s |-> ##2
    remappable_io_pin_oe[0] == RPS_FN_VALID_MASK[$past(pwdata[5:0], 2)])
    else $error("pin zero enable wrong after map write");
  oe_quiet_a: assert property ($changed(remappable_io_pin_oe) |->
    $past(psel && penable && pwrite, 2))
    else $error("pin enables moved without a write");
  pin_uart_a: assert property ($past(code0_q) == 6'h03 |->
    remappable_io_pin_out[0] == $past(serial_transmit[0]))
    else $error("pin zero not serial transmit");
  pin_rts_a: assert property ($past(code0_q) == 6'h04 |->
    remappable_io_pin_out[0] == ($past(serial_infrared_mode[0]) ?
    $past(serial_infrared_bclk[0]) : $past(serial_request_to_send[0])))
    else $error("pin zero not request to send");
  pin_comp_a: assert property ($past(code0_q) == 6'h24 |->
    remappable_io_pin_out[0] == $past(comparator_out[2]))
    else $error("pin zero not comparator three");
  pin_spi_a: assert property ($past(code0_q) == 6'h08 |->
    remappable_io_pin_out[0] == $past(spi_clock_out[0]))
    else $error("pin zero not spi one clock");
  pin_compare_a: assert property ($past(code0_q) == 6'h23 |->
    remappable_io_pin_out[0] == $past(compare_channel_out[8]))
    else $error("pin zero not compare channel nine");
endmodule
bind rps_remappable_pin_select rps_checker i_chk (.*);
`default_nettype wire

// >>> bench/rps_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module rps_periph_model (
  input wire logic ref_clk, // clock
  input wire logic load, // take new levels
  input wire logic [95:0] rnd, // random source
  output logic [2:0] comparator_out, // comparators
  output logic [3:0] serial_transmit, // transmit
  output logic [3:0] serial_request_to_send, // rts
  output logic [3:0] serial_infrared_mode, // infrared mode
  output logic [3:0] serial_infrared_bclk, // infrared bit clock
  output logic [2:0] spi_data_out, // spi data
  output logic [2:0] spi_clock_out, // spi clocks
  output logic [2:0] spi_select_out, // spi selects
  output logic [8:0] compare_channel_out, // compare channels
  output logic [rps_pkg::RPS_NUM_PINS-1:0] remappable_pin_in // pads
);
  import rps_pkg::*;
  // ==========================================================
  // levels hold between loads so a check sees one frozen snapshot
  always @(posedge ref_clk) begin
    if (load) begin
      {comparator_out, serial_transmit, serial_request_to_send,
       serial_infrared_mode, serial_infrared_bclk, spi_data_out,
       spi_clock_out, spi_select_out} <= rnd[27:0];
      compare_channel_out <= rnd[36:28];
      remappable_pin_in <= rnd[95:50];
    end
  end
endmodule
`default_nettype wire

// >>> bench/rps_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rps_pkg::*;
  // ==========================================================
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, load = 1'b0;
  logic [RPS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = '0;
  logic [95:0] rnd = '0;
  logic pready, pslverr;
  logic [2:0] comparator_out, spi_data_out, spi_clock_out, spi_select_out;
  logic [3:0] serial_transmit, serial_request_to_send;
  logic [3:0] serial_infrared_mode, serial_infrared_bclk;
  logic [8:0] compare_channel_out;
  logic [RPS_NUM_PINS-1:0] remappable_pin_in;
  logic [31:0] remappable_io_pin_out, remappable_io_pin_oe;
  logic fixed_alt_spi_clock_pin_out, fixed_alt_spi_clock_pin_oe;
  logic spi_two_clock_in, spi_two_data_in, spi_two_select_in;
  logic serial_four_cts_in, serial_four_rx_in;
  logic spi_three_clock_in, spi_three_data_in;
  logic [15:0] pin_digital_mode, converter_sample_enable;
  logic band_gap_scan_enable, half_band_gap_scan_enable;
  int bad_count = 0, check_count = 0;
  logic [31:0] seed = 32'h01DFD455;
  logic [15:0] rg [0:22];
  always #2 ref_clk = ~ref_clk;
  rps_periph_model i_periph (.*);
  rps_remappable_pin_select i_dut (.*);
  // ==========================================================
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] msk(int r);
    case (r)
      17: return 16'h003F;
      20: return 16'h0001;
      21: return 16'hFFFF;
      22: return 16'h0003;
      default: return 16'h3F3F;
    endcase
  endfunction
  function automatic logic sig(logic [5:0] c);
    logic [63:0] v;
    logic [3:0] rts;
    v = '0;
    rts = (serial_infrared_mode & serial_infrared_bclk) |
          (~serial_infrared_mode & serial_request_to_send);
    v[2:1] = comparator_out[1:0];
    v[36] = comparator_out[2];
    for (int k = 0; k < 4; k++) begin
      v[k < 2 ? 3 + 2 * k : 24 + 2 * k] = serial_transmit[k];
      v[k < 2 ? 4 + 2 * k : 25 + 2 * k] = rts[k];
    end
    for (int k = 0; k < 3; k++) begin
      v[k < 2 ? 7 + 3 * k : 32] = spi_data_out[k];
      v[k < 2 ? 8 + 3 * k : 33] = spi_clock_out[k];
      v[k < 2 ? 9 + 3 * k : 34] = spi_select_out[k];
    end
    v[25:18] = compare_channel_out[7:0];
    v[35] = compare_channel_out[8];
    return v[c];
  endfunction
  function automatic logic pin(logic [5:0] s);
    return (s < RPS_NUM_PINS) ? remappable_pin_in[s] : 1'b0;
  endfunction
  task automatic chk(logic [32:0] seen, logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ==========================================================
  // apb master: holds the request until pready is seen high or 20 cycles pass
  task automatic apb(logic wr, int r, logic [31:0] d, logic [3:0] s,
                     output logic [32:0] rsp);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 8'(r * 4);
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rsp = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) bad_count++;
  endtask
  task automatic wr_reg(int r, logic [31:0] d, logic [3:0] s);
    logic [32:0] rsp;
    logic [15:0] m;
    m = msk(r) & {{8{s[1]}}, {8{s[0]}}};
    apb(1'b1, r, d, s, rsp);
    rg[r] = (rg[r] & ~m) | (d[15:0] & m);
    chk(rsp[32], 1'b0);
  endtask
  task automatic read_all();
    logic [32:0] rsp;
    for (int r = 0; r < 23; r++) begin
      apb(1'b0, r, 32'h0, 4'h0, rsp);
      chk(rsp, {17'h0, rg[r]});
    end
    apb(1'b0, 25, 32'h0, 4'h0, rsp);
    chk(rsp, 33'h1_0000_0000);
  endtask
  task automatic shuffle();
    @(posedge ref_clk);
    rnd <= {xs(), xs(), xs()};
    load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic check_all();
    logic [31:0] eo, ee;
    logic [6:0] rs, er;
    logic [5:0] c;
    for (int p = 0; p < 32; p++) begin
      c = p[0] ? rg[p / 2][13:8] : rg[p / 2][5:0];
      ee[p] = (c >= 1 && c <= 12) || (c >= 18 && c <= 25) ||
              (c >= 28 && c <= 36);
      eo[p] = sig(c);
    end
    rs = {spi_two_clock_in, spi_two_data_in, spi_two_select_in,
          serial_four_cts_in, serial_four_rx_in, spi_three_clock_in,
          spi_three_data_in};
    er = {pin(rg[16][13:8]), pin(rg[16][5:0]), pin(rg[17][5:0]),
          pin(rg[18][13:8]), pin(rg[18][5:0]), pin(rg[19][13:8]),
          pin(rg[19][5:0])};
    chk(remappable_io_pin_oe, ee);
    chk(remappable_io_pin_out, eo);
    chk(rs, er);
    chk({pin_digital_mode, ~converter_sample_enable}, {rg[21], rg[21]});
    chk({band_gap_scan_enable, half_band_gap_scan_enable},
        {~rg[22][1], ~rg[22][0]});
    chk(fixed_alt_spi_clock_pin_oe, rg[20][0]);
    if (rg[20][0]) chk(fixed_alt_spi_clock_pin_out, spi_clock_out[0]);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 23; r++) begin
      rg[r] = (r >= 16 && r <= 19) ? msk(r) : 16'h0000;
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  initial begin
    logic [31:0] x;
    do_reset();
    shuffle();
    check_all();
    read_all();
    for (int c = 0; c < 64; c++) begin
      wr_reg(0, {18'h0, 6'(63 - c), 2'b0, 6'(c)}, 4'h3);
      shuffle();
      check_all();
    end
    for (int i = 0; i < 300; i++) begin
      x = xs();
      wr_reg(x[31:16] % 23, xs(), x[3:0]);
      shuffle();
      check_all();
    end
    read_all();
    do_reset();
    shuffle();
    check_all();
    read_all();
    close_out();
  end
  initial begin
    #80000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
